// File: design/sssc_ctrl.sv
// Notes on behaviour
// - In S3 level one sleep indication asserted, levels two and three inactive.
// - In S4 levels one and two asserted, level three inactive.
// - In S5 all three sleep indications asserted until wake.
// - In S3 memory stays in self-refresh so contents are retained.
// - In S3 external clocks stop; real-time and ring oscillator clocks run.
// - Waking from S5 starts a full boot, not a context resume.
// - In G3 no wake event is recognised.
// - System clocks run in all S0 package states, stop in S3-S5.
// - Memory power-up state drives clock enable high.
// - Precharge power-down closes all banks first, then drops clock enable.
// - Active power-down drops clock enable with a bank still open.
// - Self-refresh drops clock enable so the DRAM refreshes itself.
`timescale 1ns/10ps
`default_nettype none
`include "sssc_map.svh"
module sssc_ctrl
    import sssc_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_sleep_req,
    input wire logic [2:0] i_sleep_state,
    input wire logic i_wake,
    input wire logic i_power_good,
    input wire logic [1:0] i_mc_req,
    input wire logic i_banks_open,
    output logic o_sleep_level_one_ind,
    output logic o_sleep_level_two_ind,
    output logic o_sleep_level_three_ind,
    output logic o_sys_clk_en,
    output logic o_rtc_clk_en,
    output logic o_ring_osc_en,
    output logic o_mem_cke,
    output logic o_mem_self_refresh,
    output logic o_precharge_all,
    output logic o_full_boot,
    output logic o_resume,
    output logic o_run,
    output logic [2:0] o_state
);
    // Wake and power-good pins from the platform pass two flip-flops first
    logic wake_s1_reg;
    logic wake_s2_reg;
    logic pg_s1_reg;
    logic pg_s2_reg;
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            wake_s1_reg <= 1'b0;
            wake_s2_reg <= 1'b0;
            pg_s1_reg <= 1'b0;
            pg_s2_reg <= 1'b0;
        end else begin
            wake_s1_reg <= i_wake;
            wake_s2_reg <= wake_s1_reg;
            pg_s1_reg <= i_power_good;
            pg_s2_reg <= pg_s1_reg;
        end
    end

    sssc_state_t state_reg;
    sssc_state_t state_next;
    sssc_mc_t mc_reg;
    sssc_mc_t mc_next;
    logic from_s5_reg;
    logic from_s5_next;
    logic pend_reg;
    logic pend_next;
    logic boot_reg;
    logic resume_reg;

    // Wake ignored in G3: no power for wake logic
    wire wake_ok = wake_s2_reg && (state_reg != SSSC_G3);
    wire in_s0 = (state_reg == SSSC_S0);
    wire want_ppd = (i_mc_req == `SSSC_MC_PPD);
    // Memory may leave self-refresh only while S0 holds now and next cycle
    wire stay_s0 = in_s0 && (state_next == SSSC_S0);

    // Global state transitions
    always_comb begin
        state_next = state_reg;
        from_s5_next = from_s5_reg;
        pend_next = 1'b0;
        case (state_reg)
            SSSC_S0: begin
                if (i_sleep_req) begin
                    case (i_sleep_state)
                        `SSSC_REQ_S3: state_next = SSSC_S3;
                        `SSSC_REQ_S4: state_next = SSSC_S4;
                        `SSSC_REQ_S5: state_next = SSSC_S5;
                        `SSSC_REQ_G3: state_next = SSSC_G3;
                        default: state_next = SSSC_S0;
                    endcase
                end
            end
            SSSC_S3, SSSC_S4, SSSC_S5: begin
                if (!pg_s2_reg) begin
                    state_next = SSSC_G3;
                    from_s5_next = 1'b1;
                end else if (wake_ok) begin
                    state_next = SSSC_S0;
                    from_s5_next = (state_reg != SSSC_S3);
                    pend_next = 1'b1;
                end
            end
            SSSC_G3: begin
                // Power return always cold-boots; context was lost
                if (pg_s2_reg) begin
                    state_next = SSSC_S0;
                    from_s5_next = 1'b1;
                    pend_next = 1'b1;
                end
            end
            default: state_next = SSSC_G3;
        endcase
    end

    // Memory controller power state; sleep forces self-refresh on the entry edge
    always_comb begin
        mc_next = mc_reg;
        if (!stay_s0) begin
            mc_next = SSSC_MSR;
        end else if (pend_reg) begin
            mc_next = SSSC_MUP;
        end else begin
            case (i_mc_req)
                `SSSC_MC_UP: mc_next = SSSC_MUP;
                `SSSC_MC_PPD: mc_next = i_banks_open ? mc_reg : SSSC_MPPD;
                `SSSC_MC_APD: mc_next = i_banks_open ? SSSC_MAPD : mc_reg;
                `SSSC_MC_SR: mc_next = SSSC_MSR;
                default: mc_next = SSSC_MUP;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= SSSC_G3;
            mc_reg <= SSSC_MSR;
            from_s5_reg <= 1'b1;
            pend_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            mc_reg <= mc_next;
            from_s5_reg <= from_s5_next;
            pend_reg <= pend_next;
        end
    end

    // One-cycle boot or resume pulse after indications have cleared
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            boot_reg <= 1'b0;
            resume_reg <= 1'b0;
        end else begin
            boot_reg <= pend_reg && from_s5_reg;
            resume_reg <= pend_reg && !from_s5_reg;
        end
    end

    // Indications decoded from the next state so they change with the state
    wire lvl1 = (state_next != SSSC_S0);
    wire lvl2 = (state_next == SSSC_S4) || (state_next == SSSC_S5)
        || (state_next == SSSC_G3);
    wire lvl3 = (state_next == SSSC_S5) || (state_next == SSSC_G3);
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_sleep_level_one_ind <= 1'b1;
            o_sleep_level_two_ind <= 1'b1;
            o_sleep_level_three_ind <= 1'b1;
            o_sys_clk_en <= 1'b0;
            o_mem_cke <= 1'b0;
            o_mem_self_refresh <= 1'b1;
            o_precharge_all <= 1'b0;
        end else begin
            o_sleep_level_one_ind <= lvl1;
            o_sleep_level_two_ind <= lvl2;
            o_sleep_level_three_ind <= lvl3;
            o_sys_clk_en <= (state_next == SSSC_S0);
            o_mem_cke <= (mc_next == SSSC_MUP);
            o_mem_self_refresh <= (mc_next == SSSC_MSR);
            o_precharge_all <= stay_s0 && want_ppd && i_banks_open;
        end
    end

    // Real-time clock never gated; ring oscillator runs except in G3
    assign o_rtc_clk_en = 1'b1;
    assign o_ring_osc_en = (state_reg != SSSC_G3);
    assign o_full_boot = boot_reg;
    assign o_resume = resume_reg;
    assign o_run = in_s0 && !pend_reg;
    assign o_state = state_reg;

    // Checks
    s3_ind_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        $past(state_reg) == SSSC_S3 && state_reg == SSSC_S3 |->
        o_sleep_level_one_ind && !o_sleep_level_two_ind && !o_sleep_level_three_ind)
        else $error("S3 indications wrong");
    s4_ind_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        $past(state_reg) == SSSC_S4 && state_reg == SSSC_S4 |->
        o_sleep_level_one_ind && o_sleep_level_two_ind && !o_sleep_level_three_ind)
        else $error("S4 indications wrong");
    s5_ind_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        $past(state_reg) == SSSC_S5 && state_reg == SSSC_S5 |->
        o_sleep_level_one_ind && o_sleep_level_two_ind && o_sleep_level_three_ind)
        else $error("S5 indications wrong");
    s3_refresh_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        state_reg == SSSC_S3 |->
        o_mem_self_refresh && !o_mem_cke && o_rtc_clk_en && o_ring_osc_en)
        else $error("S3 memory not retained");
    s5_boot_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        state_reg == SSSC_S5 && state_next == SSSC_S0 |-> ##2 o_full_boot && !o_resume)
        else $error("No full boot after S5");
    g3_wake_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        state_reg == SSSC_G3 && !pg_s2_reg |=> state_reg == SSSC_G3)
        else $error("Wake taken in G3");
    clk_run_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        ##1 (state_reg == SSSC_S0) == o_sys_clk_en)
        else $error("System clock gating wrong");
    cke_up_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        ##1 (mc_reg == SSSC_MUP) == o_mem_cke)
        else $error("Clock enable wrong");
    ppd_bank_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        in_s0 && mc_reg != SSSC_MPPD && mc_next == SSSC_MPPD |-> !i_banks_open)
        else $error("Precharge power-down with open bank");
    apd_bank_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        in_s0 && mc_reg != SSSC_MAPD && mc_next == SSSC_MAPD |-> i_banks_open)
        else $error("Active power-down without open bank");
    wake_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        o_run |-> !o_sleep_level_one_ind && !o_sleep_level_two_ind && !o_sleep_level_three_ind)
        else $error("Running with sleep indicated");
    s3_cov: cover property (@(posedge i_ref_clk) disable iff (i_rst)
        state_reg == SSSC_S3 ##1 state_reg == SSSC_S0);
    s5_cov: cover property (@(posedge i_ref_clk) disable iff (i_rst) o_full_boot);
    sr_cov: cover property (@(posedge i_ref_clk) disable iff (i_rst)
        in_s0 && mc_reg == SSSC_MSR);
endmodule : sssc_ctrl
`default_nettype wire

// File: design/sssc_map.svh
`ifndef SSSC_MAP_SVH
`define SSSC_MAP_SVH
// Sleep state request codes
`define SSSC_REQ_S0 3'h0
`define SSSC_REQ_S3 3'h3
`define SSSC_REQ_S4 3'h4
`define SSSC_REQ_S5 3'h5
`define SSSC_REQ_G3 3'h7
// Memory controller request codes
`define SSSC_MC_UP 2'h0
`define SSSC_MC_PPD 2'h1
`define SSSC_MC_APD 2'h2
`define SSSC_MC_SR 2'h3
`endif

// File: design/sssc_pkg.sv
package sssc_pkg;
    typedef enum logic [2:0] {
        SSSC_S0 = 3'b000,
        SSSC_S3 = 3'b011,
        SSSC_S4 = 3'b100,
        SSSC_S5 = 3'b101,
        SSSC_G3 = 3'b111
    } sssc_state_t;
    typedef enum logic [1:0] {
        SSSC_MUP = 2'b00,
        SSSC_MPPD = 2'b01,
        SSSC_MAPD = 2'b10,
        SSSC_MSR = 2'b11
    } sssc_mc_t;
endpackage : sssc_pkg

// File: sim/sssc_platform_model.sv
`timescale 1ns/10ps
`default_nettype none
module sssc_platform_model #(
    parameter int PG_DLY = 4,
    parameter int CLOSE_DLY = 3
) (
    input wire logic i_ref_clk,
    input wire logic i_supply_on,
    input wire logic i_activate,
    input wire logic i_precharge_all,
    output logic o_power_good,
    output logic o_banks_open
);
    int pg_cnt = 0;
    int close_cnt = 0;
    // Outputs start low so no unknown reaches the synchronisers
    initial begin
        o_power_good = 1'b0;
        o_banks_open = 1'b0;
    end
    // Power good waits for the supply to settle, but drops at once on loss
    always @(negedge i_ref_clk) begin
        if (!i_supply_on) begin
            o_power_good <= 1'b0;
            pg_cnt <= 0;
        end else if (pg_cnt == PG_DLY) begin
            o_power_good <= 1'b1;
        end else begin
            pg_cnt <= pg_cnt + 1;
        end
    end
    // Banks close slowly after precharge-all, and stay shut until reactivated
    always @(negedge i_ref_clk) begin
        if (!i_activate) begin
            o_banks_open <= 1'b0;
            close_cnt <= 0;
        end else if (i_precharge_all) begin
            if (close_cnt == CLOSE_DLY) begin
                o_banks_open <= 1'b0;
            end else begin
                close_cnt <= close_cnt + 1;
            end
        end else if (close_cnt == 0) begin
            o_banks_open <= 1'b1;
        end
    end
endmodule : sssc_platform_model
`default_nettype wire

// File: sim/sleep_state_signal_control_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module sleep_state_signal_control_tb_top import sssc_pkg::*;;
    logic clk, rst, slp_req, wake, supply, act;
    logic [2:0] code;
    logic [1:0] mc;
    wire logic pg, banks, l1, l2, l3, sclk, rtc, ring, cke, sr, pre, boot, res, run;
    wire logic [2:0] st;
    int bad_count = 0;
    int n_checks = 0;
    sssc_ctrl dut (.i_ref_clk(clk), .i_rst(rst), .i_sleep_req(slp_req), .i_sleep_state(code),
        .i_wake(wake), .i_power_good(pg), .i_mc_req(mc), .i_banks_open(banks),
        .o_sleep_level_one_ind(l1), .o_sleep_level_two_ind(l2), .o_sleep_level_three_ind(l3),
        .o_sys_clk_en(sclk), .o_rtc_clk_en(rtc), .o_ring_osc_en(ring), .o_mem_cke(cke),
        .o_mem_self_refresh(sr), .o_precharge_all(pre), .o_full_boot(boot), .o_resume(res),
        .o_run(run), .o_state(st));
    sssc_platform_model plat (.i_ref_clk(clk), .i_supply_on(supply), .i_activate(act),
        .i_precharge_all(pre), .o_power_good(pg), .o_banks_open(banks));
    // 200 MHz reference
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    function automatic logic [7:0] snap();
        return {l1, l2, l3, sclk, rtc, ring, cke, sr};
    endfunction : snap
    // Waits for S0, then gathers the boot and resume pulses
    task wait_s0(input logic [1:0] pulse);
        int k;
        logic [1:0] seen;
        seen = 2'h0;
        k = 0;
        while (st !== SSSC_S0 && k < 20) begin
            @(negedge clk);
            k++;
        end
        wake = 1'b0;
        repeat (5) begin
            @(negedge clk);
            seen = seen | {boot, res};
        end
        chk({6'h00, seen}, {6'h00, pulse});
        chk(snap(), 8'h1E);
        chk({7'h00, run}, 8'h01);
    endtask : wait_s0
    task t_sleep(input sssc_state_t s, input logic [7:0] exp, input logic [1:0] pulse);
        code = s;
        slp_req = 1'b1;
        @(negedge clk);
        chk(snap(), exp);
        slp_req = 1'b0;
        @(negedge clk);
        chk({5'h00, st}, {5'h00, s});
        repeat (6) @(negedge clk);
        chk(snap(), exp);
        wake = 1'b1;
        wait_s0(pulse);
    endtask : t_sleep
    // Supply lost in S3 falls to G3, where a wake is ignored
    task t_loss;
        code = SSSC_S3;
        slp_req = 1'b1;
        @(negedge clk);
        slp_req = 1'b0;
        supply = 1'b0;
        // Wake only once G3 is reached, so it cannot race the power loss
        repeat (6) @(negedge clk);
        chk({5'h00, st}, {5'h00, SSSC_G3});
        wake = 1'b1;
        repeat (8) @(negedge clk);
        chk({5'h00, st}, {5'h00, SSSC_G3});
        chk(snap(), 8'hE9);
        wake = 1'b0;
        supply = 1'b1;
        wait_s0(2'b10);
    endtask : t_loss
    // Unknown codes are ignored; a G3 request drops to G3 and cold-boots
    task t_codes;
        code = 3'h1;
        slp_req = 1'b1;
        @(negedge clk);
        slp_req = 1'b0;
        @(negedge clk);
        chk(snap(), 8'h1E);
        code = SSSC_G3;
        slp_req = 1'b1;
        @(negedge clk);
        slp_req = 1'b0;
        chk({5'h00, st}, {5'h00, SSSC_G3});
        wait_s0(2'b10);
    endtask : t_codes
    task t_mem;
        int k;
        act = 1'b1;
        // Banks must be open before the request, or the model races it
        repeat (2) @(negedge clk);
        mc = SSSC_MPPD;
        k = 0;
        while (pre !== 1'b1 && k < 10) begin
            @(negedge clk);
            k++;
        end
        chk({6'h00, pre, cke}, 8'h03);
        repeat (8) @(negedge clk);
        chk({5'h00, pre, cke, sr}, 8'h00);
        mc = SSSC_MUP;
        act = 1'b0;
        repeat (3) @(negedge clk);
        chk({6'h00, cke, sr}, 8'h02);
        act = 1'b1;
        repeat (2) @(negedge clk);
        mc = SSSC_MAPD;
        repeat (3) @(negedge clk);
        chk({6'h00, cke, sr}, 8'h00);
        mc = SSSC_MSR;
        repeat (3) @(negedge clk);
        chk({6'h00, cke, sr}, 8'h01);
        mc = SSSC_MUP;
        act = 1'b0;
        repeat (3) @(negedge clk);
    endtask : t_mem
    task summarize;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize
    // Main sequence; all inputs change on the falling edge
    initial begin
        rst = 1'b1;
        slp_req = 1'b0;
        wake = 1'b0;
        supply = 1'b0;
        act = 1'b0;
        code = SSSC_S0;
        mc = SSSC_MUP;
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk(snap(), 8'hE9);
        supply = 1'b1;
        wait_s0(2'b10);
        t_sleep(SSSC_S3, 8'h8D, 2'b01);
        t_sleep(SSSC_S4, 8'hCD, 2'b10);
        t_sleep(SSSC_S5, 8'hED, 2'b10);
        t_codes;
        t_mem;
        t_loss;
        summarize;
    end
    // Whole run is under two hundred cycles; this cuts a hang short
    initial begin
        #20000;
        bad_count++;
        summarize;
    end
endmodule : sleep_state_signal_control_tb_top
`default_nettype wire
